// file: src/mmf_cfg.svh
// constants for the memory model feature register block
`ifndef MMF_CFG_SVH
`define MMF_CFG_SVH

`define MMF_CP_NUM        4'hf
`define MMF_SYN_OPC1      3'h4
`define MMF_SYN_OPC2      3'h0
`define MMF_SYN_CRN       4'h5
`define MMF_SYN_CRM       4'h2
`define MMF_ID_OPC1       3'h0
`define MMF_ID_CRN        4'h0
`define MMF_ID_CRM        4'h1
`define MMF_ID0_OPC2      3'h4
`define MMF_ID2_OPC2      3'h6
`define MMF_SYN_RESET     32'h0000_0000

// feature field values
`define MMF_INNER_SHR     4'hf
`define MMF_CTX_EXT       4'h0
`define MMF_AUX_REG       4'h2
`define MMF_TCM           4'h1
`define MMF_SHARE_LVL     4'h1
`define MMF_OUTER_SHR     4'hf
`define MMF_PROT_SCHEME   4'h4
`define MMF_VIRT_SCHEME   4'h0
`define MMF_HW_ACC_FLAG   4'h0
`define MMF_WFI_STALL     4'h1
`define MMF_BARRIER       4'h2
`define MMF_UNI_TLB       4'h0
`define MMF_SPLIT_TLB     4'h0
`define MMF_L1_RANGE      4'h0
`define MMF_L1_BG         4'h0
`define MMF_L1_FG         4'h0

`endif

// file: src/mmf_pkg.sv
// types for the memory model feature register block
package mmf_pkg;
    typedef enum logic [1:0] {
        MMF_LVL_USER   = 2'b00,
        MMF_LVL_KERNEL = 2'b01,
        MMF_LVL_HYP    = 2'b10
    } mmf_level_t;

    typedef enum logic [1:0] {
        MMF_RES_OK    = 2'b00,
        MMF_RES_TRAP  = 2'b01,
        MMF_RES_UNDEF = 2'b10
    } mmf_result_t;
endpackage

// file: src/mmf_regs.sv
// syndrome register and memory model feature identification registers
`timescale 1ns/1ns
`include "mmf_cfg.svh"

module mmf_regs
    import mmf_pkg::*;
#(
    parameter logic [3:0] INNER_SHR  = `MMF_INNER_SHR,
    parameter logic [3:0] TCM_SUP    = `MMF_TCM,
    parameter logic [3:0] OUTER_SHR  = `MMF_OUTER_SHR,
    parameter logic [3:0] WFI_STALL  = `MMF_WFI_STALL
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // coprocessor access request
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [3:0]  acc_coproc,
    input  wire logic [2:0]  acc_opc1,
    input  wire logic [2:0]  acc_opc2,
    input  wire logic [3:0]  acc_crn,
    input  wire logic [3:0]  acc_crm,
    input  wire logic [1:0]  acc_level,
    input  wire logic [31:0] acc_wdata,
    // trap controls from other blocks
    input  wire logic        trap_group5_bit,
    input  wire logic        trap_group0_bit,
    input  wire logic        trap_id_group_bit,
    // syndrome load from exception logic
    input  wire logic        syn_load,
    input  wire logic [31:0] syn_load_data,
    // response
    output logic             resp_valid,
    output logic             resp_hit,
    output logic [1:0]       resp_result,
    output logic [31:0]      resp_rdata,
    output logic [31:0]      hyp_syndrome_reg
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic enc_match(input logic [2:0] o1, input logic [2:0] o2,
                                       input logic [3:0] n, input logic [3:0] m);
        enc_match = (acc_coproc == `MMF_CP_NUM) && (acc_opc1 == o1) && (acc_opc2 == o2)
                    && (acc_crn == n) && (acc_crm == m);
    endfunction

    logic             hit_syn;
    logic             hit_id0;
    logic             hit_id2;
    logic             is_user;
    logic             is_kernel;
    logic [31:0]      mmf0_val;
    logic [31:0]      mmf2_val;
    mmf_result_t      result_next;
    logic [31:0]      rdata_next;
    logic             syn_wr;
    // helpers for the checks below, built from the inputs alone
    logic             id_trapped;
    logic             id0_rd_ok;
    logic             id2_rd_ok;

    assign hit_syn   = enc_match(`MMF_SYN_OPC1, `MMF_SYN_OPC2, `MMF_SYN_CRN, `MMF_SYN_CRM);
    assign hit_id0   = enc_match(`MMF_ID_OPC1, `MMF_ID0_OPC2, `MMF_ID_CRN, `MMF_ID_CRM);
    assign hit_id2   = enc_match(`MMF_ID_OPC1, `MMF_ID2_OPC2, `MMF_ID_CRN, `MMF_ID_CRM);
    assign is_user   = (acc_level == MMF_LVL_USER);
    assign is_kernel = (acc_level == MMF_LVL_KERNEL);
    assign id_trapped = is_kernel && (trap_id_group_bit || trap_group0_bit);
    assign id0_rd_ok  = acc_valid && hit_id0 && !acc_write && !is_user && !id_trapped;
    assign id2_rd_ok  = acc_valid && hit_id2 && !acc_write && !is_user && !id_trapped;

    ////////////////////////////////////////////////////////////////////////////
    // feature register contents, constant by construction

    // level field fixed at two levels, so innermost field is always meaningful
    assign mmf0_val = {INNER_SHR,
                       `MMF_CTX_EXT,
                       `MMF_AUX_REG,
                       TCM_SUP,
                       `MMF_SHARE_LVL,
                       OUTER_SHR,
                       `MMF_PROT_SCHEME,
                       `MMF_VIRT_SCHEME};

    // unified field zero, so split field carries no meaning and reads zero
    assign mmf2_val = {`MMF_HW_ACC_FLAG,
                       WFI_STALL,
                       `MMF_BARRIER,
                       `MMF_UNI_TLB,
                       `MMF_SPLIT_TLB,
                       `MMF_L1_RANGE,
                       `MMF_L1_BG,
                       `MMF_L1_FG};

    ////////////////////////////////////////////////////////////////////////////
    // access checking; encoding is checked first, user and feature-write undefined outrank trap, kernel syndrome trap outranks undefined

    always_comb begin
        result_next = MMF_RES_OK;
        rdata_next  = 32'h0000_0000;
        syn_wr      = 1'b0;
        if (hit_syn) begin
            if (is_user) begin
                result_next = MMF_RES_UNDEF;
            end else if (is_kernel && trap_group5_bit) begin
                result_next = MMF_RES_TRAP;
            end else if (is_kernel) begin
                result_next = MMF_RES_UNDEF;
            end else if (acc_write) begin
                syn_wr = 1'b1;
            end else begin
                rdata_next = hyp_syndrome_reg;
            end
        end else if (hit_id0 || hit_id2) begin
            if (is_user || acc_write) begin
                result_next = MMF_RES_UNDEF;
            end else if (is_kernel && (trap_id_group_bit || trap_group0_bit)) begin
                result_next = MMF_RES_TRAP;
            end else if (hit_id0) begin
                rdata_next = mmf0_val;
            end else begin
                rdata_next = mmf2_val;
            end
        end else begin
            // unmapped encodings, unimplemented auxiliary registers included
            result_next = MMF_RES_UNDEF;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // syndrome register; software write wins over exception load

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            hyp_syndrome_reg <= `MMF_SYN_RESET;
        end else if (acc_valid && syn_wr) begin
            hyp_syndrome_reg <= acc_wdata;
        end else if (syn_load) begin
            hyp_syndrome_reg <= syn_load_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered response, one cycle after the request

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            resp_valid  <= 1'b0;
            resp_hit    <= 1'b0;
            resp_result <= MMF_RES_OK;
            resp_rdata  <= 32'h0000_0000;
        end else begin
            resp_valid  <= acc_valid;
            resp_hit    <= acc_valid && (hit_syn || hit_id0 || hit_id2);
            resp_result <= acc_valid ? result_next : MMF_RES_OK;
            resp_rdata  <= (acc_valid && !acc_write) ? rdata_next : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_SYN_TRAP: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_syn && is_kernel && trap_group5_bit |=> resp_result == MMF_RES_TRAP)
        else $error("kernel syndrome access did not trap");

    AST_SYN_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_syn && acc_level == MMF_LVL_HYP && acc_write
        |=> hyp_syndrome_reg == $past(acc_wdata) && resp_result == MMF_RES_OK)
        else $error("hyp syndrome write not stored");

    AST_SYN_PROTECT: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_syn && (is_user || is_kernel) && !syn_load
        |=> $stable(hyp_syndrome_reg) && resp_result != MMF_RES_OK)
        else $error("syndrome reached below hyp level");

    AST_ID_TRAP: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && (hit_id0 || hit_id2) && is_kernel && !acc_write
        && (trap_id_group_bit || trap_group0_bit) |=> resp_result == MMF_RES_TRAP)
        else $error("feature read did not trap");

    AST_ID0_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_id0 && acc_level == MMF_LVL_HYP && !acc_write
        |=> resp_rdata[15:12] == `MMF_SHARE_LVL && resp_rdata[7:4] == `MMF_PROT_SCHEME
            && resp_rdata[23:20] == `MMF_AUX_REG && resp_rdata[27:24] == `MMF_CTX_EXT)
        else $error("feature register 0 read wrong");

    AST_ID2_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_id2 && acc_level == MMF_LVL_HYP && !acc_write
        |=> resp_rdata[23:20] == `MMF_BARRIER && resp_rdata[19:0] == 20'h00000
            && resp_rdata[31:28] == `MMF_HW_ACC_FLAG)
        else $error("feature register 2 read wrong");

    AST_ID_UNDEF: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && (hit_id0 || hit_id2) && (is_user || acc_write)
        |=> resp_result == MMF_RES_UNDEF && resp_rdata == 32'h0000_0000)
        else $error("illegal feature access not undefined");

    AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && !hit_syn && !hit_id0 && !hit_id2 |=> resp_result == MMF_RES_UNDEF && !resp_hit)
        else $error("unmapped access not undefined");

    ////////////////////////////////////////////////////////////////////////////
    // field checks; parameters may move some fields, so legal sets are checked

    AST_INNER_SHR: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[31:28] inside {4'h0, 4'h1, 4'hf})
        else $error("innermost shareability field illegal");

    AST_INNER_VALID: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[15:12] == `MMF_SHARE_LVL && resp_rdata[31:28] == INNER_SHR)
        else $error("innermost shareability not backed by level field");

    AST_CTX_EXT: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[27:24] == `MMF_CTX_EXT)
        else $error("context switch extension field wrong");

    AST_AUX_REG: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[23:20] == `MMF_AUX_REG)
        else $error("auxiliary register field wrong");

    AST_TCM: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[19:16] inside {4'h0, 4'h1})
        else $error("tightly coupled memory field illegal");

    AST_SHARE_LVL: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[15:12] == 4'h1)
        else $error("shareability level field wrong");

    AST_OUTER_SHR: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[11:8] inside {4'h0, 4'h1, 4'hf})
        else $error("outermost shareability field illegal");

    AST_PROT_SCHEME: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[7:4] == `MMF_PROT_SCHEME)
        else $error("protected memory scheme field wrong");

    AST_VIRT_SCHEME: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_rdata[3:0] == `MMF_VIRT_SCHEME)
        else $error("virtual memory scheme field wrong");

    AST_HW_ACC_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[31:28] == `MMF_HW_ACC_FLAG)
        else $error("hardware access flag field wrong");

    AST_WFI_STALL: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[27:24] inside {4'h0, 4'h1})
        else $error("wait stall field illegal");

    AST_BARRIER: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[23:20] == `MMF_BARRIER)
        else $error("barrier field wrong");

    AST_UNI_TLB: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[19:16] == `MMF_UNI_TLB)
        else $error("unified maintenance field wrong");

    AST_SPLIT_TLB: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[15:12] == `MMF_SPLIT_TLB)
        else $error("split translation buffer field wrong");

    AST_L1_RANGE: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[11:8] == `MMF_L1_RANGE)
        else $error("range maintenance field wrong");

    AST_L1_BG: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[7:4] == `MMF_L1_BG)
        else $error("background prefetch field wrong");

    AST_L1_FG: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_rdata[3:0] == `MMF_L1_FG)
        else $error("foreground prefetch field wrong");

    AST_ID0_ENC: assert property (@(posedge sys_clk) disable iff (!nrst)
        id0_rd_ok |=> resp_hit && resp_result == MMF_RES_OK)
        else $error("feature register 0 encoding not decoded");

    AST_ID2_ENC: assert property (@(posedge sys_clk) disable iff (!nrst)
        id2_rd_ok |=> resp_hit && resp_result == MMF_RES_OK)
        else $error("feature register 2 encoding not decoded");

    ////////////////////////////////////////////////////////////////////////////
    // syndrome and response checks

    AST_SYN_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_syn && !is_user && !is_kernel && !acc_write
        |=> resp_rdata == $past(hyp_syndrome_reg) && resp_result == MMF_RES_OK)
        else $error("hyp syndrome read wrong");

    AST_SYN_USER: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_syn && is_user |=> resp_result == MMF_RES_UNDEF)
        else $error("user syndrome access not undefined");

    AST_SYN_KERNEL: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_syn && is_kernel && !trap_group5_bit |=> resp_result == MMF_RES_UNDEF)
        else $error("kernel syndrome access not undefined");

    AST_SYN_TRAP_DATA: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && hit_syn && is_kernel && trap_group5_bit |=> resp_rdata == 32'h0000_0000 && resp_hit)
        else $error("trapped syndrome access returned data");

    AST_ID_TRAP_DATA: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && (hit_id0 || hit_id2) && !acc_write && id_trapped |=> resp_rdata == 32'h0000_0000)
        else $error("trapped feature read returned data");

    AST_ID_HYP_NOTRAP: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && (hit_id0 || hit_id2) && !acc_write && !is_user && !is_kernel
        |=> resp_result == MMF_RES_OK)
        else $error("hyp feature read trapped");

    AST_WRITE_NODATA: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid && acc_write |=> resp_rdata == 32'h0000_0000)
        else $error("write returned read data");

    AST_RESP_VALID: assert property (@(posedge sys_clk) disable iff (!nrst)
        acc_valid |=> resp_valid)
        else $error("response missing");

    AST_RESP_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
        !acc_valid |=> !resp_valid && !resp_hit && resp_result == MMF_RES_OK)
        else $error("response without request");

    AST_SYN_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst)
        syn_load && !(acc_valid && hit_syn && !is_user && !is_kernel && acc_write)
        |=> hyp_syndrome_reg == $past(syn_load_data))
        else $error("syndrome load lost");

    AST_SYN_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        !syn_load && !(acc_valid && acc_write) |=> $stable(hyp_syndrome_reg))
        else $error("syndrome changed without write or load");

endmodule // mmf_regs

// file: testbench/tb_top.sv
// self-checking testbench for the memory model feature register block
`timescale 1ns/1ns
`include "mmf_cfg.svh"

module tb_top
    import mmf_pkg::*;
;
    logic        sys_clk, nrst, acc_valid, acc_write, syn_load;
    logic        trap_group5_bit, trap_group0_bit, trap_id_group_bit;
    logic [3:0]  acc_coproc, acc_crn, acc_crm;
    logic [2:0]  acc_opc1, acc_opc2;
    logic [1:0]  acc_level, resp_result;
    logic [31:0] acc_wdata, syn_load_data, resp_rdata, hyp_syndrome_reg;
    logic        resp_valid, resp_hit;
    int          err_total, cmp_count;
    // expected words built field by field from the chosen defaults
    localparam logic [31:0] FEAT0 = 32'hf021_1f40;
    localparam logic [31:0] FEAT2 = 32'h0120_0000;

    mmf_regs u_dut (.sys_clk(sys_clk), .nrst(nrst), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_coproc(acc_coproc), .acc_opc1(acc_opc1), .acc_opc2(acc_opc2), .acc_crn(acc_crn),
        .acc_crm(acc_crm), .acc_level(acc_level), .acc_wdata(acc_wdata),
        .trap_group5_bit(trap_group5_bit), .trap_group0_bit(trap_group0_bit),
        .trap_id_group_bit(trap_id_group_bit), .syn_load(syn_load), .syn_load_data(syn_load_data),
        .resp_valid(resp_valid), .resp_hit(resp_hit), .resp_result(resp_result),
        .resp_rdata(resp_rdata), .hyp_syndrome_reg(hyp_syndrome_reg));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one access, answer judged one cycle after it is driven, 1 ns after the edge that takes it
    task automatic acc(input logic wr, input logic [2:0] o1, input logic [2:0] o2, input logic [3:0] n,
                       input logic [3:0] m, input logic [1:0] lvl, input logic [31:0] wd,
                       input logic [1:0] res, input logic hit, input logic [31:0] rd);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_opc1 <= o1;
        acc_opc2 <= o2;
        acc_crn <= n;
        acc_crm <= m;
        acc_level <= lvl;
        acc_wdata <= wd;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        #1;
        chk("resp_valid", 32'(1'b1), 32'(resp_valid));
        chk("resp_hit", 32'(hit), 32'(resp_hit));
        chk("resp_result", 32'(res), 32'(resp_result));
        chk("resp_rdata", rd, resp_rdata);
    endtask

    task automatic feat(input logic wr, input logic [2:0] o2, input logic [1:0] lvl, input logic [1:0] res,
                        input logic hit, input logic [31:0] rd);
        acc(wr, `MMF_ID_OPC1, o2, `MMF_ID_CRN, `MMF_ID_CRM, lvl, 32'h5a5a_a5a5, res, hit, rd);
    endtask

    task automatic syn(input logic wr, input logic [1:0] lvl, input logic [31:0] wd, input logic [1:0] res,
                       input logic [31:0] rd);
        acc(wr, `MMF_SYN_OPC1, `MMF_SYN_OPC2, `MMF_SYN_CRN, `MMF_SYN_CRM, lvl, wd, res, 1'b1, rd);
    endtask

    task automatic set_traps(input logic g5, input logic g0, input logic idg);
        @(posedge sys_clk);
        trap_group5_bit <= g5;
        trap_group0_bit <= g0;
        trap_id_group_bit <= idg;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_feat_read;
        feat(1'b0, `MMF_ID0_OPC2, MMF_LVL_HYP, MMF_RES_OK, 1'b1, FEAT0);
        feat(1'b0, `MMF_ID0_OPC2, MMF_LVL_KERNEL, MMF_RES_OK, 1'b1, FEAT0);
        feat(1'b0, `MMF_ID2_OPC2, MMF_LVL_HYP, MMF_RES_OK, 1'b1, FEAT2);
        feat(1'b0, `MMF_ID2_OPC2, MMF_LVL_KERNEL, MMF_RES_OK, 1'b1, FEAT2);
        $display("test feat_read done");
    endtask

    task automatic t_feat_trap;
        set_traps(1'b0, 1'b0, 1'b1);
        feat(1'b0, `MMF_ID0_OPC2, MMF_LVL_KERNEL, MMF_RES_TRAP, 1'b1, 32'h0);
        feat(1'b0, `MMF_ID2_OPC2, MMF_LVL_HYP, MMF_RES_OK, 1'b1, FEAT2);
        feat(1'b1, `MMF_ID0_OPC2, MMF_LVL_KERNEL, MMF_RES_UNDEF, 1'b1, 32'h0);
        set_traps(1'b0, 1'b1, 1'b0);
        feat(1'b0, `MMF_ID2_OPC2, MMF_LVL_KERNEL, MMF_RES_TRAP, 1'b1, 32'h0);
        set_traps(1'b0, 1'b0, 1'b0);
        $display("test feat_trap done");
    endtask

    task automatic t_refuse;
        feat(1'b1, `MMF_ID2_OPC2, MMF_LVL_HYP, MMF_RES_UNDEF, 1'b1, 32'h0);
        feat(1'b0, `MMF_ID0_OPC2, MMF_LVL_USER, MMF_RES_UNDEF, 1'b1, 32'h0);
        feat(1'b0, 3'h5, MMF_LVL_HYP, MMF_RES_UNDEF, 1'b0, 32'h0);
        $display("test refuse done");
    endtask

    task automatic t_syndrome;
        syn(1'b1, MMF_LVL_HYP, 32'hdead_0001, MMF_RES_OK, 32'h0);
        chk("hyp_syndrome_reg", 32'hdead_0001, hyp_syndrome_reg);
        syn(1'b0, MMF_LVL_HYP, 32'h0, MMF_RES_OK, 32'hdead_0001);
        syn(1'b1, MMF_LVL_KERNEL, 32'h1234_5678, MMF_RES_UNDEF, 32'h0);
        syn(1'b0, MMF_LVL_USER, 32'h0, MMF_RES_UNDEF, 32'h0);
        set_traps(1'b1, 1'b0, 1'b0);
        syn(1'b1, MMF_LVL_KERNEL, 32'h1234_5678, MMF_RES_TRAP, 32'h0);
        syn(1'b0, MMF_LVL_KERNEL, 32'h0, MMF_RES_TRAP, 32'h0);
        chk("hyp_syndrome_reg", 32'hdead_0001, hyp_syndrome_reg);
        set_traps(1'b0, 1'b0, 1'b0);
        // exception side load, then read back by software
        @(posedge sys_clk);
        syn_load <= 1'b1;
        syn_load_data <= 32'hbeef_0042;
        @(posedge sys_clk);
        syn_load <= 1'b0;
        syn(1'b0, MMF_LVL_HYP, 32'h0, MMF_RES_OK, 32'hbeef_0042);
        $display("test syndrome done");
    endtask

    // write and exception load in one cycle: software write wins
    task automatic t_collide;
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_write <= 1'b1;
        acc_opc1 <= `MMF_SYN_OPC1;
        acc_opc2 <= `MMF_SYN_OPC2;
        acc_crn <= `MMF_SYN_CRN;
        acc_crm <= `MMF_SYN_CRM;
        acc_level <= MMF_LVL_HYP;
        acc_wdata <= 32'h7777_0001;
        syn_load <= 1'b1;
        syn_load_data <= 32'h0bad_0bad;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        syn_load <= 1'b0;
        #1;
        chk("hyp_syndrome_reg", 32'h7777_0001, hyp_syndrome_reg);
        syn(1'b0, 2'h3, 32'h0, MMF_RES_OK, 32'h7777_0001);
        $display("test collide done");
    endtask

    // reset in mid-run clears the syndrome; first access right after release
    task automatic t_reset;
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk("hyp_syndrome_reg", `MMF_SYN_RESET, hyp_syndrome_reg);
        chk("resp_valid", 32'h0, 32'(resp_valid));
        syn(1'b0, MMF_LVL_HYP, 32'h0, MMF_RES_OK, `MMF_SYN_RESET);
        $display("test reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        #200000;
        err_total++;
        end_of_test;
    end

    initial begin
        {nrst, acc_valid, acc_write, syn_load, trap_group5_bit, trap_group0_bit, trap_id_group_bit} = '0;
        {acc_crn, acc_crm, acc_opc1, acc_opc2, acc_level} = '0;
        acc_coproc = `MMF_CP_NUM;
        acc_wdata = 32'h0;
        syn_load_data = 32'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk("hyp_syndrome_reg", `MMF_SYN_RESET, hyp_syndrome_reg);
        chk("resp_valid", 32'h0, 32'(resp_valid));
        t_feat_read;
        t_feat_trap;
        t_refuse;
        t_syndrome;
        t_collide;
        t_reset;
        end_of_test;
    end
endmodule // tb_top
